// File: hdl/zxp_defines.svh
/*
 * Constants of the zero-crossing and line timing block: timebase rates,
 * filter shift, status bit positions and reset values.
 * Assumes inclusion by bare name from every design file of the block except the package.
 */
`ifndef ZXP_DEFINES_SVH
`define ZXP_DEFINES_SVH

// system clock and fast timebase, both in kHz
`define ZXP_CLK_KHZ 15'h61A8
`define ZXP_FAST_KHZ 15'h0100
// slow timebase is the fast one divided by sixteen: last divider count
`define ZXP_SLOW_DIV 4'hF
// one-pole filter: 2*pi*80 Hz / 256 kHz is close to 2**-9
`define ZXP_LPF_SHIFT 4'h9
// ten percent of the full-scale sample amplitude
`define ZXP_VOLT_MIN 24'h090BBA
`define ZXP_TIMEOUT_RST 16'hFFFF
`define ZXP_ONE 16'h0001
`define ZXP_COUNT_MAX 16'hFFFF
// status bit positions and the set of implemented bits
`define ZXP_BIT_TO0 5'h03
`define ZXP_BIT_ZX0 5'h09
`define ZXP_BIT_SEQ 5'h13
`define ZXP_STATUS_IMPL 32'h00087FF8
// last voltage phase index
`define ZXP_PHASE_C 2'h2

`endif

// File: hdl/zxp_pkg.sv
/*
 * Types of the zero-crossing and line timing block.
 * Assumes nothing of its surroundings.
 */
package zxp_pkg;
    typedef logic signed [23:0] zxp_sample_t;
    typedef logic [15:0] zxp_count_t;
    typedef enum logic [1:0] {
        ZXP_PAIR_VOLT_CURR,
        ZXP_PAIR_VOLT_VOLT,
        ZXP_PAIR_CURR_CURR,
        ZXP_PAIR_NONE
    } zxp_pair_e;
    typedef struct packed {
        zxp_sample_t held;
        logic signed [33:0] filt;
        logic [23:0] peak;
        logic neg;
        logic zx_any;
        logic zx_rise;
    } zxp_det_s;
    typedef struct packed {
        zxp_count_t cnt;
        logic armed;
        logic expired;
    } zxp_tmo_s;
    typedef struct packed {
        logic [14:0] acc;
        logic tick_fast;
        logic [3:0] slow_cnt;
        logic tick_slow;
        zxp_count_t timeout_val;
        logic [31:0] status;
        logic [1:0] last_phase;
        logic last_valid;
        zxp_count_t now;
        logic [2:0][15:0] stamp;
        logic [2:0] started;
        logic [2:0][15:0] delay;
        zxp_count_t per_cnt;
        zxp_count_t period;
    } zxp_top_s;
endpackage

// File: hdl/zxp_zx_detect.sv
/*
 * One zero-crossing detector: holds the latest filtered sample, runs a
 * one-pole low-pass on the fast tick and flags sign changes.
 * Assumes samples arrive with a one-cycle valid strobe.
 */
`timescale 1ns/1ps
`include "zxp_defines.svh"
module zxp_zx_detect
    import zxp_pkg::*;
(
    input wire logic clk_sys,
    input wire logic arst_n,
    input wire logic tick_fast,
    input wire logic sample_valid,
    input wire zxp_sample_t sample,
    input wire logic gate_en,
    output logic zx_any,
    output logic zx_rise
);
    zxp_det_s q;
    zxp_det_s d;
    logic signed [33:0] filt_new;
    logic [23:0] mag;
    logic qualified;

    always_comb begin
        d = q;
        d.zx_any = 1'b0;
        d.zx_rise = 1'b0;
        mag = sample[23] ? 24'(-sample) : 24'(sample);
        filt_new = q.filt + 34'(q.held) - (q.filt >>> `ZXP_LPF_SHIFT);
        qualified = !gate_en || (q.peak >= `ZXP_VOLT_MIN);
        if (sample_valid) begin
            d.held = sample;
            if (mag > q.peak) begin
                d.peak = mag;
            end
        end
        if (tick_fast) begin
            d.filt = filt_new;
            if (filt_new[33] != q.neg) begin
                d.neg = filt_new[33];
                d.peak = '0;
                d.zx_any = qualified;
                d.zx_rise = qualified && q.neg;
            end
        end
    end

    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            q <= '0;
        end else begin
            q <= d;
        end
    end

    assign zx_any = q.zx_any;
    assign zx_rise = q.zx_rise;
endmodule // zxp_zx_detect

// File: hdl/zxp_timeout.sv
/*
 * Crossing timeout counter for one detector, counting on the slow tick.
 * Assumes reload is a one-cycle pulse carrying the value to load.
 */
`timescale 1ns/1ps
`include "zxp_defines.svh"
module zxp_timeout
    import zxp_pkg::*;
(
    input wire logic clk_sys,
    input wire logic arst_n,
    input wire logic tick_slow,
    input wire logic reload,
    input wire zxp_count_t load_value,
    output logic expired
);
    zxp_tmo_s q;
    zxp_tmo_s d;

    always_comb begin
        d = q;
        d.expired = 1'b0;
        if (reload) begin
            d.cnt = load_value;
            d.armed = 1'b1;
        end else if (tick_slow && q.armed) begin
            d.cnt = q.cnt - `ZXP_ONE;
            if (q.cnt <= `ZXP_ONE) begin
                d.cnt = '0;
                d.armed = 1'b0;
                d.expired = 1'b1;
            end
        end
    end

    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            q <= '{cnt: `ZXP_TIMEOUT_RST, armed: 1'b1, expired: 1'b0};
        end else begin
            q <= d;
        end
    end

    assign expired = q.expired;

    property p_tmo_dec;
        @(posedge clk_sys) disable iff (!arst_n)
        tick_slow && q.armed && !reload && q.cnt > `ZXP_ONE |=> q.cnt == $past(q.cnt) - `ZXP_ONE;
    endproperty
    a_tmo_dec: assert property (p_tmo_dec) else $error("timeout count did not step");

    property p_tmo_once;
        @(posedge clk_sys) disable iff (!arst_n)
        q.expired |-> !q.armed && q.cnt == '0 ##1 !q.expired;
    endproperty
    a_tmo_once: assert property (p_tmo_once) else $error("timeout flagged twice");

    property p_tmo_stop;
        @(posedge clk_sys) disable iff (!arst_n)
        !q.armed && !reload |=> !q.expired && $stable(q.cnt);
    endproperty
    a_tmo_stop: assert property (p_tmo_stop) else $error("stopped counter moved");
endmodule // zxp_timeout

// File: hdl/zxp_top.sv
/*
 * Zero-crossing timing block: six detectors, crossing timeouts, phase
 * rotation check, phase delay and line period measurement, status flags
 * with write-one-to-clear and an active-low interrupt.
 * Assumes filtered samples from the upstream chain with one valid strobe,
 * and register accesses presented as one-cycle write strobes.
 */
`timescale 1ns/1ps
`include "zxp_defines.svh"
// Function
// - crossings come from a fixed 80 Hz low-pass run on the 256 kHz tick.
// - voltage crossings are dropped while the amplitude stays under ten percent.
// - current crossings are never amplitude gated.
// - six detectors; voltage flags at bits 9-11, current flags at 12-14.
// - a set crossing flag with its mask bit pulls the interrupt low.
// - writing one to a status bit clears it, unless set again in that cycle, and releases the interrupt.
// - each detector has a timeout counter stepping down every 62.5 us.
// - a crossing reloads its counter with the programmed timeout.
// - the programmed timeout resets to all ones.
// - a counter reaching zero sets its flag, bits 3-8.
// - rising voltage crossings out of A-B-C order set bit 19.
// - every out-of-order rising crossing sets bit 19 again.
// - bit 19 with its mask bit pulls the interrupt low; write-one clears.
// - rising crossings start and stop delays; one set chosen by select.
// - select 00 gives voltage-to-current delay of phases A, B, C.
// - select 01 gives voltage delays A-C, B-C, A-B.
// - select 10 gives current delays A-C, B-C, A-B.
// - delays are 16-bit unsigned counts of 256 kHz ticks.
// - line period measured on the selected phase voltage, once per period.
// - period counted in 256 kHz ticks, about 5120 at 50 Hz.
// - period count is the tick count minus one.
module zxp_top
    import zxp_pkg::*;
(
    input wire logic clk_sys,
    input wire logic arst_n,
    input wire logic sample_valid,
    input wire zxp_sample_t sample_volt_a,
    input wire zxp_sample_t sample_volt_b,
    input wire zxp_sample_t sample_volt_c,
    input wire zxp_sample_t sample_curr_a,
    input wire zxp_sample_t sample_curr_b,
    input wire zxp_sample_t sample_curr_c,
    input wire logic timeout_wr_en,
    input wire zxp_count_t timeout_wr_data,
    input wire logic status_wr_en,
    input wire logic [31:0] status_wr_data,
    input wire logic [31:0] event_enable_second,
    input wire logic [1:0] delay_pair_select,
    input wire logic [1:0] period_phase_select,
    output logic [31:0] event_status_second,
    output zxp_count_t crossing_timeout_value,
    output zxp_count_t phase_delay_0,
    output zxp_count_t phase_delay_1,
    output zxp_count_t phase_delay_2,
    output zxp_count_t line_period,
    output logic event_irq_n
);
    zxp_top_s q;
    zxp_top_s d;

    zxp_sample_t samples [6];
    logic [5:0] zx_any;
    logic [5:0] zx_rise;
    logic [5:0] expired;
    logic [5:0] gate_en;
    zxp_count_t load_value;
    logic [31:0] set_vec;
    logic [31:0] clr_vec;
    logic [14:0] acc_sum;
    logic [1:0] per_sel;
    logic [5:0] pair;
    zxp_pair_e mode;
    logic seq_err;

    // next phase in regular A-B-C rotation
    function automatic logic [1:0] zxp_next_phase(input logic [1:0] p);
        zxp_next_phase = (p == `ZXP_PHASE_C) ? 2'h0 : p + 2'h1;
    endfunction

    // start and stop channel of delay slot m; channels 0-2 voltage, 3-5 current
    function automatic logic [5:0] zxp_pair_src(input zxp_pair_e md, input logic [1:0] m);
        logic [2:0] vs;
        logic [2:0] vt;
        vs = (m == 2'h2) ? 3'h0 : {1'b0, m};
        vt = (m == 2'h2) ? 3'h1 : 3'h2;
        unique case (md)
            ZXP_PAIR_VOLT_CURR: zxp_pair_src = {1'b0, m, {1'b0, m} + 3'h3};
            ZXP_PAIR_VOLT_VOLT: zxp_pair_src = {vs, vt};
            ZXP_PAIR_CURR_CURR: zxp_pair_src = {vs + 3'h3, vt + 3'h3};
            ZXP_PAIR_NONE: zxp_pair_src = 6'h00;
        endcase
    endfunction

    assign samples[0] = sample_volt_a;
    assign samples[1] = sample_volt_b;
    assign samples[2] = sample_volt_c;
    assign samples[3] = sample_curr_a;
    assign samples[4] = sample_curr_b;
    assign samples[5] = sample_curr_c;

    assign gate_en = 6'h07;
    assign load_value = timeout_wr_en ? timeout_wr_data : q.timeout_val;
    assign mode = zxp_pair_e'(delay_pair_select);

    for (genvar ch = 0; ch < 6; ch++) begin : g_chan
        zxp_zx_detect u_det (
            .clk_sys(clk_sys),
            .arst_n(arst_n),
            .tick_fast(q.tick_fast),
            .sample_valid(sample_valid),
            .sample(samples[ch]),
            .gate_en(gate_en[ch]),
            .zx_any(zx_any[ch]),
            .zx_rise(zx_rise[ch])
        );
        zxp_timeout u_tmo (
            .clk_sys(clk_sys),
            .arst_n(arst_n),
            .tick_slow(q.tick_slow),
            .reload(zx_any[ch] | timeout_wr_en),
            .load_value(load_value),
            .expired(expired[ch])
        );
    end

    always_comb begin
        d = q;
        d.tick_fast = 1'b0;
        d.tick_slow = 1'b0;
        set_vec = '0;
        seq_err = 1'b0;
        pair = '0;

        // fractional divider: average rate of exactly 256 kHz from 25 MHz
        acc_sum = q.acc + `ZXP_FAST_KHZ;
        if (acc_sum >= `ZXP_CLK_KHZ) begin
            d.acc = acc_sum - `ZXP_CLK_KHZ;
            d.tick_fast = 1'b1;
        end else begin
            d.acc = acc_sum;
        end
        if (q.tick_fast) begin
            d.now = q.now + `ZXP_ONE;
            d.slow_cnt = q.slow_cnt + 4'h1;
            d.tick_slow = (q.slow_cnt == `ZXP_SLOW_DIV);
            if (q.per_cnt != `ZXP_COUNT_MAX) begin
                d.per_cnt = q.per_cnt + `ZXP_ONE;
            end
        end

        if (timeout_wr_en) begin
            d.timeout_val = timeout_wr_data;
        end

        for (int ch = 0; ch < 6; ch++) begin
            set_vec[`ZXP_BIT_ZX0 + ch] = zx_any[ch];
            set_vec[`ZXP_BIT_TO0 + ch] = expired[ch];
        end

        // rotation check on rising voltage crossings
        for (int p = 0; p < 3; p++) begin
            if (zx_rise[p]) begin
                if (q.last_valid && 2'(p) != zxp_next_phase(d.last_phase)) begin
                    seq_err = 1'b1;
                end
                d.last_phase = 2'(p);
                d.last_valid = 1'b1;
            end
        end
        set_vec[`ZXP_BIT_SEQ] = seq_err;

        clr_vec = status_wr_en ? status_wr_data : '0;
        d.status = ((q.status & ~clr_vec) | set_vec) & `ZXP_STATUS_IMPL;

        // delay slots: stop handled before start so a shared channel restarts
        for (int m = 0; m < 3; m++) begin
            pair = zxp_pair_src(mode, 2'(m));
            if (mode != ZXP_PAIR_NONE) begin
                if (zx_rise[pair[2:0]] && q.started[m]) begin
                    d.delay[m] = q.now - q.stamp[m];
                    d.started[m] = 1'b0;
                end
                if (zx_rise[pair[5:3]]) begin
                    d.stamp[m] = q.now;
                    d.started[m] = 1'b1;
                end
            end else begin
                d.started[m] = 1'b0;
            end
        end

        per_sel = (period_phase_select == 2'h3) ? 2'h0 : period_phase_select;
        if (zx_rise[per_sel]) begin
            d.period = (q.per_cnt == '0) ? '0 : q.per_cnt - `ZXP_ONE;
            d.per_cnt = '0;
        end
    end

    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            q <= '0;
            q.timeout_val <= `ZXP_TIMEOUT_RST;
        end else begin
            q <= d;
        end
    end

    assign event_status_second = q.status;
    assign crossing_timeout_value = q.timeout_val;
    assign phase_delay_0 = q.delay[0];
    assign phase_delay_1 = q.delay[1];
    assign phase_delay_2 = q.delay[2];
    assign line_period = q.period;
    assign event_irq_n = ~|(q.status & event_enable_second);

    // helper copies for the checks below
    zxp_count_t per_cnt_h;
    logic [1:0] last_phase_h;
    logic last_valid_h;
    assign per_cnt_h = q.per_cnt;
    assign last_phase_h = q.last_phase;
    assign last_valid_h = q.last_valid;

    property p_zx_flag;
        @(posedge clk_sys) disable iff (!arst_n)
        zx_any[3] |=> event_status_second[12];
    endproperty
    a_zx_flag: assert property (p_zx_flag) else $error("current A crossing flag not set");

    property p_irq_low;
        @(posedge clk_sys) disable iff (!arst_n)
        zx_any[0] && event_enable_second[9] ##1 event_enable_second[9] |-> !event_irq_n;
    endproperty
    a_irq_low: assert property (p_irq_low) else $error("interrupt not asserted");

    property p_w1c;
        @(posedge clk_sys) disable iff (!arst_n)
        status_wr_en && status_wr_data[9] && !zx_any[0] |=> !event_status_second[9];
    endproperty
    a_w1c: assert property (p_w1c) else $error("write one did not clear flag");

    property p_tmo_flag;
        @(posedge clk_sys) disable iff (!arst_n)
        expired[2] |=> event_status_second[5];
    endproperty
    a_tmo_flag: assert property (p_tmo_flag) else $error("timeout flag not set");

    property p_seq_err;
        @(posedge clk_sys) disable iff (!arst_n)
        last_valid_h && last_phase_h == 2'h0 && zx_rise[2:0] == 3'h4 |=> event_status_second[19];
    endproperty
    a_seq_err: assert property (p_seq_err) else $error("rotation error missed");

    property p_seq_clr;
        @(posedge clk_sys) disable iff (!arst_n)
        status_wr_en && status_wr_data[19] && !seq_err && event_enable_second == 32'h00080000
        ##1 event_enable_second == 32'h00080000 |-> event_irq_n;
    endproperty
    a_seq_clr: assert property (p_seq_clr) else $error("rotation flag not cleared");

    property p_hold_to;
        @(posedge clk_sys) disable iff (!arst_n)
        !timeout_wr_en |=> $stable(crossing_timeout_value);
    endproperty
    a_hold_to: assert property (p_hold_to) else $error("timeout value changed unasked");

    property p_period;
        @(posedge clk_sys) disable iff (!arst_n)
        period_phase_select == 2'h0 && zx_rise[0] && per_cnt_h != '0
        |=> line_period == $past(per_cnt_h) - `ZXP_ONE;
    endproperty
    a_period: assert property (p_period) else $error("period count wrong");

    property p_delay_hold;
        @(posedge clk_sys) disable iff (!arst_n)
        delay_pair_select == 2'h0 && !zx_rise[3] |=> $stable(phase_delay_0);
    endproperty
    a_delay_hold: assert property (p_delay_hold) else $error("delay changed off stop");

    property p_tick_gap;
        @(posedge clk_sys) disable iff (!arst_n)
        q.tick_fast |-> ##[97:98] q.tick_fast;
    endproperty
    a_tick_gap: assert property (p_tick_gap) else $error("fast tick spacing off");

    property p_slow_tick;
        @(posedge clk_sys) disable iff (!arst_n)
        q.tick_slow |-> $past(q.tick_fast);
    endproperty
    a_slow_tick: assert property (p_slow_tick) else $error("slow tick off the fast one");

    property p_to_write;
        @(posedge clk_sys) disable iff (!arst_n)
        timeout_wr_en |=> crossing_timeout_value == $past(timeout_wr_data);
    endproperty
    a_to_write: assert property (p_to_write) else $error("timeout value not written");

    property p_zx_volt_c;
        @(posedge clk_sys) disable iff (!arst_n)
        zx_any[2] |=> event_status_second[11];
    endproperty
    a_zx_volt_c: assert property (p_zx_volt_c) else $error("voltage C flag not set");

    property p_per_restart;
        @(posedge clk_sys) disable iff (!arst_n)
        zx_rise[per_sel] |=> per_cnt_h == '0;
    endproperty
    a_per_restart: assert property (p_per_restart) else $error("period count not restarted");

    property p_per_step;
        @(posedge clk_sys) disable iff (!arst_n)
        q.tick_fast && !zx_rise[per_sel] && per_cnt_h != `ZXP_COUNT_MAX
        |=> per_cnt_h == $past(per_cnt_h) + `ZXP_ONE;
    endproperty
    a_per_step: assert property (p_per_step) else $error("period count did not step");

    property p_seq_again;
        @(posedge clk_sys) disable iff (!arst_n)
        last_valid_h && last_phase_h == 2'h2 && zx_rise[2:0] == 3'h2 |=> event_status_second[19];
    endproperty
    a_seq_again: assert property (p_seq_again) else $error("repeated rotation error missed");

    property p_seq_ok;
        @(posedge clk_sys) disable iff (!arst_n)
        last_valid_h && last_phase_h == 2'h0 && zx_rise[2:0] == 3'h2 && !event_status_second[19]
        |=> !event_status_second[19];
    endproperty
    a_seq_ok: assert property (p_seq_ok) else $error("rotation error in regular order");

    property p_delay_volt;
        @(posedge clk_sys) disable iff (!arst_n)
        delay_pair_select == 2'h1 && !zx_rise[2] |=> $stable(phase_delay_0) && $stable(phase_delay_1);
    endproperty
    a_delay_volt: assert property (p_delay_volt) else $error("voltage delay off stop");

    property p_delay_curr;
        @(posedge clk_sys) disable iff (!arst_n)
        delay_pair_select == 2'h2 && !zx_rise[5] |=> $stable(phase_delay_0) && $stable(phase_delay_1);
    endproperty
    a_delay_curr: assert property (p_delay_curr) else $error("current delay off stop");

    property p_delay_none;
        @(posedge clk_sys) disable iff (!arst_n)
        delay_pair_select == 2'h3
        |=> $stable(phase_delay_0) && $stable(phase_delay_1) && $stable(phase_delay_2);
    endproperty
    a_delay_none: assert property (p_delay_none) else $error("delay changed with no set");
endmodule // zxp_top

// File: test/zxp_host_model.sv
/*
 * Host model: writes the timeout and status registers and holds the mask
 * and select levels of the zero-crossing timing block.
 * Assumes one clock; a write is taken at the edge where its strobe is high.
 */
`timescale 1ns/1ps
module zxp_host_model (
    input wire logic clk_sys,
    output logic timeout_wr_en,
    output logic [15:0] timeout_wr_data,
    output logic status_wr_en,
    output logic [31:0] status_wr_data,
    output logic [31:0] event_enable_second,
    output logic [1:0] delay_pair_select,
    output logic [1:0] period_phase_select
);
    initial begin
        timeout_wr_en = 1'b0;
        timeout_wr_data = 16'h0000;
        status_wr_en = 1'b0;
        status_wr_data = 32'h00000000;
        event_enable_second = 32'h00000000;
        delay_pair_select = 2'h0;
        period_phase_select = 2'h0;
    end
    task automatic wr_timeout(input logic [15:0] v);
        @(posedge clk_sys);
        timeout_wr_en <= 1'b1;
        timeout_wr_data <= v;
        @(posedge clk_sys);
        timeout_wr_en <= 1'b0;
    endtask
    // events are acknowledged only by writing ones to their bits
    task automatic ack(input logic [31:0] m);
        @(posedge clk_sys);
        status_wr_en <= 1'b1;
        status_wr_data <= m;
        @(posedge clk_sys);
        status_wr_en <= 1'b0;
    endtask
    // rotation error trusted: wiring is four-wire with three voltage sensors
    task automatic set_cfg(input logic [31:0] m, input logic [1:0] ds, input logic [1:0] ps);
        @(posedge clk_sys);
        event_enable_second <= m;
        delay_pair_select <= ds;
        period_phase_select <= ps;
    endtask
endmodule // zxp_host_model

// File: test/test_zxp_top.sv
/*
 * Testbench of the zero-crossing timing block: square-wave channels with
 * set phase offsets, host model for register writes.
 * Assumes a 25 MHz clock; the filter turns squares into centred triangles.
 */
`timescale 1ns/1ps
module test_zxp_top;
    import zxp_pkg::*;
    localparam int HP = 1953;
    localparam int P = 2 * HP;
    localparam int SLOW = 1563;
    localparam int PR [3][6] = '{'{0, 3, 1, 4, 2, 5}, '{0, 2, 1, 2, 0, 1}, '{3, 5, 4, 5, 3, 4}};
    localparam zxp_sample_t AMP = 24'h200000;
    localparam zxp_sample_t AMP_LO = 24'h040000;
    logic clk_sys, arst_n, sample_valid, run;
    logic timeout_wr_en, status_wr_en, event_irq_n;
    logic [15:0] timeout_wr_data;
    logic [31:0] status_wr_data, event_enable_second, status;
    logic [1:0] delay_pair_select, period_phase_select;
    zxp_count_t tov, period;
    zxp_count_t dly [3];
    zxp_sample_t smp [6];
    zxp_sample_t amp [6];
    int off [6];
    int tc, n_fail, num_checks;

    zxp_top zxp_top_inst (.clk_sys(clk_sys), .arst_n(arst_n), .sample_valid(sample_valid),
        .sample_volt_a(smp[0]), .sample_volt_b(smp[1]), .sample_volt_c(smp[2]),
        .sample_curr_a(smp[3]), .sample_curr_b(smp[4]), .sample_curr_c(smp[5]),
        .timeout_wr_en(timeout_wr_en), .timeout_wr_data(timeout_wr_data),
        .status_wr_en(status_wr_en), .status_wr_data(status_wr_data),
        .event_enable_second(event_enable_second), .delay_pair_select(delay_pair_select),
        .period_phase_select(period_phase_select), .event_status_second(status),
        .crossing_timeout_value(tov), .phase_delay_0(dly[0]), .phase_delay_1(dly[1]),
        .phase_delay_2(dly[2]), .line_period(period), .event_irq_n(event_irq_n));
    zxp_host_model zxp_host_model_inst (.clk_sys(clk_sys), .timeout_wr_en(timeout_wr_en),
        .timeout_wr_data(timeout_wr_data), .status_wr_en(status_wr_en),
        .status_wr_data(status_wr_data), .event_enable_second(event_enable_second),
        .delay_pair_select(delay_pair_select), .period_phase_select(period_phase_select));

    initial begin
        clk_sys = 1'b0;
        forever #20 clk_sys = ~clk_sys;
    end

    // square wave starting with a half segment so the filtered triangle is centred
    function automatic zxp_sample_t wave(input int k);
        int t;
        t = tc - off[k];
        if (t < 0) return '0;
        return (((t + HP / 2) / HP) % 2) ? -amp[k] : amp[k];
    endfunction

    always @(posedge clk_sys) begin
        sample_valid <= ~sample_valid;
        if (run) tc <= tc + 1;
        for (int k = 0; k < 6; k++) smp[k] <= wave(k);
    end

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        num_checks++;
        if (got !== exp) begin
            n_fail++;
            $display("wrong value at %0t: got %0h expected %0h", $time, got, exp);
        end
    endtask
    task automatic rng(input logic [31:0] got, input logic [31:0] lo, input logic [31:0] hi);
        num_checks++;
        if ((got >= lo && got <= hi) !== 1'b1) begin
            n_fail++;
            $display("wrong value at %0t: got %0h expected %0h to %0h", $time, got, lo, hi);
        end
    endtask
    task automatic cyc(input int n);
        repeat (n) @(posedge clk_sys);
        #1;
    endtask
    task automatic start(input int vb, input int vc, input zxp_sample_t alo);
        @(posedge clk_sys);
        arst_n <= 1'b0;
        run <= 1'b0;
        off <= '{0, vb, vc, 500, vb + 1000, vc + 1500};
        amp <= '{AMP, AMP, alo, AMP, AMP, alo};
        repeat (6) @(posedge clk_sys);
        arst_n <= 1'b1;
        run <= 1'b1;
        // restart here, where the wave process no longer steps tc
        tc <= 0;
        #1;
    endtask
    task automatic chk_delays(input int m);
        int d;
        int e;
        for (int j = 0; j < 3; j++) begin
            d = (off[PR[m][2 * j + 1]] - off[PR[m][2 * j]] + P) % P;
            e = d * 256 / 25000;
            rng(dly[j], e, e + 1);
        end
    endtask

    task automatic t_reset;
        chk(status, 32'h00000000);
        chk(tov, 16'hFFFF);
        chk(event_irq_n, 1'b1);
    endtask
    task automatic t_cross;
        cyc(3 * P);
        chk(status[14:9], 6'h3F);
        for (int b = 9; b < 15; b++) begin
            zxp_host_model_inst.set_cfg(32'h1 << b, 2'h0, 2'h0);
            #1;
            chk(event_irq_n, 1'b0);
        end
        zxp_host_model_inst.ack(32'h00007E00);
        #1;
        chk(status[14:9], 6'h00);
        chk(event_irq_n, 1'b1);
        zxp_host_model_inst.wr_timeout(16'h0003);
        #1;
        chk(tov, 16'h0003);
    endtask
    task automatic t_angle;
        for (int m = 0; m < 3; m++) begin
            zxp_host_model_inst.set_cfg(32'h200, m[1:0], m[1:0]);
            cyc(2 * P + 200);
            chk_delays(m);
            rng(period, P * 256 / 25000 - 1, P * 256 / 25000);
        end
        zxp_host_model_inst.set_cfg(32'h0, 2'h3, 2'h3);
        cyc(2 * P + 200);
        chk_delays(2);
        rng(period, P * 256 / 25000 - 1, P * 256 / 25000);
        chk(status[8:3], 6'h00);
        chk(status[19], 1'b0);
    endtask
    task automatic t_rot;
        start(2604, 1302, AMP);
        cyc(8400);
        zxp_host_model_inst.set_cfg(32'h1 << 19, 2'h0, 2'h0);
        #1;
        chk(status[19], 1'b1);
        chk(event_irq_n, 1'b0);
        zxp_host_model_inst.ack(32'h1 << 19);
        #1;
        chk(status[19], 1'b0);
        chk(event_irq_n, 1'b1);
        cyc(P + 200);
        chk(status[19], 1'b1);
    endtask
    task automatic t_gate_tmo;
        start(1302, 2604, AMP_LO);
        cyc(3 * P);
        chk(status[14:9], 6'h3B);
        @(posedge clk_sys);
        run <= 1'b0;
        cyc(HP);
        zxp_host_model_inst.ack(32'hFFFFFFFF);
        zxp_host_model_inst.wr_timeout(16'h0003);
        cyc(2 * SLOW - 100);
        chk(status[8:3], 6'h00);
        cyc(SLOW + 200);
        chk(status[8:3], 6'h3F);
        zxp_host_model_inst.ack(32'h000001F8);
        cyc(2 * SLOW);
        chk(status[8:3], 6'h00);
    endtask

    task automatic end_of_test;
        $display("checks %0d mismatches %0d", num_checks, n_fail);
        if (n_fail == 0 && num_checks > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask

    initial begin
        n_fail = 0;
        num_checks = 0;
        arst_n = 1'b0;
        run = 1'b0;
        tc = 0;
        sample_valid = 1'b0;
        smp = '{default: '0};
        amp = '{default: '0};
        off = '{default: 0};
        start(1302, 2604, AMP);
        t_reset;
        t_cross;
        t_angle;
        t_rot;
        t_gate_tmo;
        end_of_test;
    end

    // a hang counts as a mismatch
    initial begin
        repeat (100000) @(posedge clk_sys);
        n_fail++;
        end_of_test;
    end
endmodule // test_zxp_top
